// ---- include/fsq_pkg.sv ----
// Purpose: Shared constants, types and decode helpers for the stack-frame sequencer.
// Assumes: 32-bit core, full register set, one core clock.
// Notes:   Register offsets are byte addresses on the plain register port.
`default_nettype none
package fsq_pkg;
	localparam int unsigned XLEN            = 32;
	localparam logic [5:0]  SLOT_BYTES      = 6'h04;
	localparam logic [7:0]  SPIMM_UNIT      = 8'h10;
	localparam logic [3:0]  RLIST_MIN_VALID = 4'h4;
	localparam logic [3:0]  RLIST_FULL      = 4'hf;
	localparam logic [3:0]  NSLOTS_FULL     = 4'hd;
	localparam logic [3:0]  RLIST_TO_NSLOTS = 4'h3;
	localparam logic [7:0]  BASE_LIST_A     = 8'h10;
	localparam logic [7:0]  BASE_LIST_B     = 8'h20;
	localparam logic [7:0]  BASE_LIST_C     = 8'h30;
	localparam logic [7:0]  BASE_LIST_D     = 8'h40;
	localparam logic [3:0]  RLIST_B_FIRST   = 4'h8;
	localparam logic [3:0]  RLIST_C_FIRST   = 4'hc;
	localparam logic [4:0]  XREG_RETURN     = 5'h01;
	localparam logic [4:0]  XREG_SAVED_LO   = 5'h08;
	localparam logic [4:0]  XREG_SAVED_HI   = 5'h10;
	localparam logic [3:0]  SAVED_LO_COUNT  = 4'h2;
	localparam logic [4:0]  CAUSE_ILLEGAL   = 5'h02;
	localparam logic [4:0]  CAUSE_LOAD_ACC  = 5'h05;
	localparam logic [4:0]  CAUSE_STORE_ACC = 5'h07;
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_COMMITS     = 8'h08;
	localparam int unsigned CTRL_IDEM_CHK   = 0;
	localparam int unsigned CTRL_WAIT_IMPR  = 1;
	localparam int unsigned CTRL_TVAL_ZERO  = 2;
	localparam logic [2:0]  CTRL_RESET      = 3'h0;
	localparam int unsigned STAT_TRAPS_LSB  = 8;

	typedef enum logic [1:0] {
		FRAME_SAVE_OP,
		FRAME_RESTORE_OP,
		FRAME_RESTORE_RETURN_OP,
		FRAME_RESTORE_RETURN_ZERO_OP
	} fsq_op_t;

	typedef struct packed {
		fsq_op_t     op;
		logic [3:0]  rlist;
		logic [1:0]  spimm;
		logic [31:0] pc;
		logic [31:0] stack_pointer;
	} fsq_req_t;

	typedef struct packed {
		logic [31:0] stack_pointer;
		logic        zero_first_arg;
		logic        ret;
	} fsq_commit_t;

	typedef struct packed {
		logic [31:0] pc;
		logic [31:0] value;
		logic [4:0]  reason;
	} fsq_trap_t;

	// Register number held in a slot; slot 0 sits just below the frame top
	function automatic logic [4:0] slot_reg(input logic [3:0] nslots, input logic [3:0] slot);
		logic [3:0] sidx;
		sidx = nslots - SAVED_LO_COUNT - slot;
		if (slot == nslots - 4'h1)
			return XREG_RETURN;
		else if (sidx < SAVED_LO_COUNT)
			return XREG_SAVED_LO + {1'b0, sidx};
		else
			return XREG_SAVED_HI + {1'b0, sidx};
	endfunction
endpackage
`default_nettype wire

// ---- logic/fsq_frame_decode.sv ----
// Purpose: Decodes register list and extra increment into slot count and frame size.
// Assumes: 32-bit core with the full register set.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fsq_frame_decode (
	// Encoding fields
	input  wire logic [3:0] i_rlist,
	input  wire logic [1:0] i_spimm,
	// Decoded frame
	output logic            o_legal,
	output logic [3:0]      o_nslots,
	output logic [7:0]      o_adj
);
	logic [7:0] base;

	always_comb begin
		o_legal = i_rlist >= fsq_pkg::RLIST_MIN_VALID;
		// Code 15 holds both top registers, so it skips one count
		if (i_rlist == fsq_pkg::RLIST_FULL)
			o_nslots = fsq_pkg::NSLOTS_FULL;
		else
			o_nslots = i_rlist - fsq_pkg::RLIST_TO_NSLOTS;
		if (i_rlist == fsq_pkg::RLIST_FULL)
			base = fsq_pkg::BASE_LIST_D;
		else if (i_rlist >= fsq_pkg::RLIST_C_FIRST)
			base = fsq_pkg::BASE_LIST_C;
		else if (i_rlist >= fsq_pkg::RLIST_B_FIRST)
			base = fsq_pkg::BASE_LIST_B;
		else
			base = fsq_pkg::BASE_LIST_A;
		o_adj = base + 8'({6'h0, i_spimm} * fsq_pkg::SPIMM_UNIT);
	end
endmodule
`default_nettype wire

// ---- logic/fsq_sequencer.sv ----
// Purpose: Expands frame save/restore instructions into word accesses and one final commit.
// Assumes: One word access outstanding; ack is a one-cycle pulse, never in the request's first cycle.
// Notes:   i_attr_nonidem describes o_mem_addr; i_rf_rdata is a combinational read of o_rf_raddr.
// Notes on behaviour
// - Adjust pointer by list size plus increments
// - Register 10 listed only together with 11
// - Restart whole sequence after every trap
// - Trap reports instruction PC, address, reason
// - Interrupts held off while sequence runs
// - Save stores may be in any order
// - Save pointer update once, after clean stores
// - Optionally wait for pending store responses
// - Example save touches sp-1 to sp-28 only
// - Restore may write registers before a fault
// - Zeroing, pointer and return commit together
// - Committed pointer increment brings return for the two return forms
// - Zero-return restore example, offsets 28 to 12
// - Non-idempotent target raises access fault
// - List 7 increment 3 saves, minus 64
// - List 15 increment 3 saves, minus 112
// - List 8 and 4 restore examples
// - Frame is base plus increment times 16
// - Base sizes 16, 32, 48, 64 by list
// - Four-byte slots downward, return link last
// - List codes 0 to 3 are reserved
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fsq_sequencer (
	// Clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst,
	// Instruction issue
	input  wire logic                  i_issue_valid,
	input  wire fsq_pkg::fsq_req_t     i_issue,
	output logic                       o_busy,
	output logic                       o_irq_hold,
	// Register file ports
	output logic [4:0]                 o_rf_raddr,
	input  wire logic [31:0]           i_rf_rdata,
	output logic                       o_rf_we,
	output logic [4:0]                 o_rf_waddr,
	output logic [31:0]                o_rf_wdata,
	// Load/store path
	output logic                       o_mem_req,
	output logic                       o_mem_we,
	output logic [31:0]                o_mem_addr,
	output logic [31:0]                o_mem_wdata,
	input  wire logic                  i_mem_ack,
	input  wire logic                  i_mem_fault,
	input  wire logic [31:0]           i_mem_rdata,
	input  wire logic                  i_attr_nonidem,
	input  wire logic                  i_store_pending,
	// Commit and trap
	output logic                       o_commit_valid,
	output fsq_pkg::fsq_commit_t       o_commit,
	output logic                       o_trap_valid,
	output fsq_pkg::fsq_trap_t         o_trap,
	// Register port
	input  wire logic [7:0]            i_reg_addr,
	input  wire logic [31:0]           i_reg_wdata,
	input  wire logic                  i_reg_we,
	input  wire logic                  i_reg_re,
	output logic [31:0]                o_reg_rdata
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ADDR,
		ST_CHECK,
		ST_ACCESS,
		ST_DRAIN
	} fsq_state_t;

	fsq_state_t        state_r;
	fsq_pkg::fsq_req_t req_r;
	logic [3:0]        slot_r;
	logic [2:0]        ctrl_r;
	logic [7:0]        trap_cnt_r;
	logic [15:0]       commit_cnt_r;
	logic              dec_legal;
	logic [3:0]        dec_nslots;
	logic [7:0]        dec_adj;
	logic              is_save;
	logic              is_ret;
	logic [3:0]        slot_plus;
	logic [31:0]       slot_offs;
	logic [31:0]       frame_top;
	logic [31:0]       slot_addr;
	logic              trap_illegal;
	logic              trap_attr;
	logic              trap_mem;
	logic              trap_any;
	logic              access_ok;
	logic              last_ok;
	logic              commit_go;

	fsq_frame_decode u_dec (
		.i_rlist  (req_r.rlist),
		.i_spimm  (req_r.spimm),
		.o_legal  (dec_legal),
		.o_nslots (dec_nslots),
		.o_adj    (dec_adj)
	);

	always_comb begin
		is_save   = req_r.op == fsq_pkg::FRAME_SAVE_OP;
		is_ret    = req_r.op == fsq_pkg::FRAME_RESTORE_RETURN_OP ||
			req_r.op == fsq_pkg::FRAME_RESTORE_RETURN_ZERO_OP;
		slot_plus = slot_r + 4'h1;
		slot_offs = 32'(slot_plus * fsq_pkg::SLOT_BYTES);
		// Restore frame top is the pointer after the increment
		frame_top = is_save ? req_r.stack_pointer : req_r.stack_pointer + {24'h0, dec_adj};
		// Pointer is untouched until commit, so every pass starts from the same base
		slot_addr = frame_top - slot_offs;
	end

	always_comb begin
		trap_illegal = state_r == ST_SETUP && !dec_legal;
		trap_attr    = state_r == ST_CHECK && i_attr_nonidem && ctrl_r[fsq_pkg::CTRL_IDEM_CHK];
		trap_mem     = state_r == ST_ACCESS && i_mem_ack && i_mem_fault;
		trap_any     = trap_illegal || trap_attr || trap_mem;
		access_ok    = state_r == ST_ACCESS && i_mem_ack && !i_mem_fault;
		last_ok      = access_ok && slot_plus == dec_nslots;
		// Imprecise errors are the platform's; optionally let them land before commit
		commit_go    = state_r == ST_DRAIN &&
			!(ctrl_r[fsq_pkg::CTRL_WAIT_IMPR] && is_save && i_store_pending);
	end

	// Sequence control
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			slot_r  <= 4'h0;
			req_r   <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					slot_r <= 4'h0;
					if (i_issue_valid) begin
						req_r   <= i_issue;
						state_r <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					state_r <= trap_illegal ? ST_IDLE : ST_ADDR;
				end
				ST_ADDR: begin
					state_r <= ST_CHECK;
				end
				ST_CHECK: begin
					state_r <= trap_attr ? ST_IDLE : ST_ACCESS;
				end
				ST_ACCESS: begin
					// A trap drops the sequence; the re-issued instruction starts at slot 0
					if (trap_mem) begin
						state_r <= ST_IDLE;
					end else if (last_ok) begin
						state_r <= ST_DRAIN;
					end else if (access_ok) begin
						slot_r  <= slot_plus;
						state_r <= ST_ADDR;
					end
				end
				ST_DRAIN: begin
					if (commit_go)
						state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Memory request
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= 32'h0;
			o_mem_wdata <= 32'h0;
			o_rf_raddr  <= 5'h0;
		end else begin
			if (state_r == ST_ADDR) begin
				o_mem_addr <= slot_addr;
				o_mem_we   <= is_save;
				o_rf_raddr <= fsq_pkg::slot_reg(dec_nslots, slot_r);
			end
			if (state_r == ST_CHECK && !trap_attr) begin
				o_mem_req   <= 1'b1;
				o_mem_wdata <= i_rf_rdata;
			end else if (state_r == ST_ACCESS && i_mem_ack) begin
				o_mem_req <= 1'b0;
			end
		end
	end

	// Restored registers land the cycle after each load returns
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rf_we    <= 1'b0;
			o_rf_waddr <= 5'h0;
			o_rf_wdata <= 32'h0;
		end else begin
			o_rf_we <= access_ok && !is_save;
			if (access_ok && !is_save) begin
				o_rf_waddr <= fsq_pkg::slot_reg(dec_nslots, slot_r);
				o_rf_wdata <= i_mem_rdata;
			end
		end
	end

	// Final commit and trap report
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_commit_valid <= 1'b0;
			o_commit       <= '0;
			o_trap_valid   <= 1'b0;
			o_trap         <= '0;
		end else begin
			o_commit_valid <= commit_go;
			if (commit_go) begin
				// One pulse carries pointer, zeroing and return, so none can land alone
				o_commit.stack_pointer  <= is_save ? req_r.stack_pointer - {24'h0, dec_adj} :
					req_r.stack_pointer + {24'h0, dec_adj};
				o_commit.zero_first_arg <= req_r.op == fsq_pkg::FRAME_RESTORE_RETURN_ZERO_OP;
				o_commit.ret            <= is_ret;
			end
			o_trap_valid <= trap_any;
			if (trap_any) begin
				o_trap.pc <= req_r.pc;
				if (trap_illegal || ctrl_r[fsq_pkg::CTRL_TVAL_ZERO])
					o_trap.value <= 32'h0;
				else
					o_trap.value <= o_mem_addr;
				if (trap_illegal)
					o_trap.reason <= fsq_pkg::CAUSE_ILLEGAL;
				else
					o_trap.reason <= is_save ? fsq_pkg::CAUSE_STORE_ACC : fsq_pkg::CAUSE_LOAD_ACC;
			end
		end
	end

	// Younger instructions and interrupts wait for commit or trap
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_busy     <= 1'b0;
			o_irq_hold <= 1'b0;
		end else if (state_r == ST_IDLE && i_issue_valid) begin
			o_busy     <= 1'b1;
			o_irq_hold <= 1'b1;
		end else if (commit_go || trap_any) begin
			o_busy     <= 1'b0;
			o_irq_hold <= 1'b0;
		end
	end

	// Counters: traps since the last commit, and commits overall
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			trap_cnt_r   <= 8'h0;
			commit_cnt_r <= 16'h0;
		end else begin
			if (commit_go)
				trap_cnt_r <= 8'h0;
			else if (trap_any && trap_cnt_r != 8'hff)
				trap_cnt_r <= trap_cnt_r + 8'h1;
			if (commit_go)
				commit_cnt_r <= commit_cnt_r + 16'h1;
		end
	end

	// Register port
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_r <= fsq_pkg::CTRL_RESET;
		end else if (i_reg_we && i_reg_addr == fsq_pkg::REG_CTRL) begin
			ctrl_r <= i_reg_wdata[2:0];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 32'h0;
		end else if (i_reg_re) begin
			unique case (i_reg_addr)
				fsq_pkg::REG_CTRL:    o_reg_rdata <= {29'h0, ctrl_r};
				fsq_pkg::REG_STATUS:  o_reg_rdata <= {16'h0, trap_cnt_r, 7'h0, o_busy};
				fsq_pkg::REG_COMMITS: o_reg_rdata <= {16'h0, commit_cnt_r};
				default:              o_reg_rdata <= 32'h0;
			endcase
		end else begin
			o_reg_rdata <= 32'h0;
		end
	end

	property p_save_sp;
		@(posedge i_core_clk) disable iff (i_rst)
		o_commit_valid && $past(is_save) |->
			o_commit.stack_pointer == $past(req_r.stack_pointer) - {24'h0, $past(dec_adj)};
	endproperty
	a_save_sp: assert property (p_save_sp) else $error("save pointer wrong");

	property p_restore_sp;
		@(posedge i_core_clk) disable iff (i_rst)
		o_commit_valid && !$past(is_save) |->
			o_commit.stack_pointer == $past(req_r.stack_pointer) + {24'h0, $past(dec_adj)};
	endproperty
	a_restore_sp: assert property (p_restore_sp) else $error("restore pointer wrong");

	property p_ret_pairs;
		@(posedge i_core_clk) disable iff (i_rst)
		o_commit_valid |-> o_commit.ret == $past(is_ret) &&
			o_commit.zero_first_arg == ($past(req_r.op) == fsq_pkg::FRAME_RESTORE_RETURN_ZERO_OP);
	endproperty
	a_ret_pairs: assert property (p_ret_pairs) else $error("return or zeroing mismatch");

	property p_one_end;
		@(posedge i_core_clk) disable iff (i_rst)
		o_commit_valid |-> !o_trap_valid ##1 !o_commit_valid;
	endproperty
	a_one_end: assert property (p_one_end) else $error("commit not single");

	property p_illegal;
		@(posedge i_core_clk) disable iff (i_rst)
		state_r == ST_SETUP && req_r.rlist < fsq_pkg::RLIST_MIN_VALID |=>
			o_trap_valid && o_trap.reason == fsq_pkg::CAUSE_ILLEGAL && !o_busy;
	endproperty
	a_illegal: assert property (p_illegal) else $error("reserved list not trapped");

	property p_save_window;
		@(posedge i_core_clk) disable iff (i_rst)
		o_mem_req && o_mem_we |->
			o_mem_addr < req_r.stack_pointer &&
			req_r.stack_pointer - o_mem_addr <= 32'(dec_nslots * fsq_pkg::SLOT_BYTES);
	endproperty
	a_save_window: assert property (p_save_window) else $error("save outside frame");

	property p_trap_pc;
		@(posedge i_core_clk) disable iff (i_rst)
		o_trap_valid |-> o_trap.pc == req_r.pc && !o_busy && state_r == ST_IDLE;
	endproperty
	a_trap_pc: assert property (p_trap_pc) else $error("trap pc or busy wrong");

	property p_nonidem;
		@(posedge i_core_clk) disable iff (i_rst)
		trap_attr |=> o_trap_valid && !o_mem_req &&
			o_trap.reason == ($past(is_save) ? fsq_pkg::CAUSE_STORE_ACC : fsq_pkg::CAUSE_LOAD_ACC);
	endproperty
	a_nonidem: assert property (p_nonidem) else $error("attribute fault missed");

	property p_first_slot;
		@(posedge i_core_clk) disable iff (i_rst)
		state_r == ST_SETUP && dec_legal |=> ##1 o_mem_addr == frame_top - 32'h4;
	endproperty
	a_first_slot: assert property (p_first_slot) else $error("restart not from first slot");

	property p_hold;
		@(posedge i_core_clk) disable iff (i_rst)
		state_r != ST_IDLE |-> o_busy && o_irq_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("not stalled mid sequence");

	property p_load_write;
		@(posedge i_core_clk) disable iff (i_rst)
		access_ok && !is_save |=> o_rf_we && o_rf_wdata == $past(i_mem_rdata);
	endproperty
	a_load_write: assert property (p_load_write) else $error("restored value lost");

	c_save:  cover property (@(posedge i_core_clk) o_commit_valid && !o_commit.ret && $past(is_save));
	c_retz:  cover property (@(posedge i_core_clk) o_commit_valid && o_commit.zero_first_arg);
	c_fault: cover property (@(posedge i_core_clk) o_trap_valid && o_trap.reason != fsq_pkg::CAUSE_ILLEGAL);
	c_ill:   cover property (@(posedge i_core_clk) o_trap_valid && o_trap.reason == fsq_pkg::CAUSE_ILLEGAL);
endmodule
`default_nettype wire

// ---- test/fsq_mem_model.sv ----
// Purpose: Load/store path stand-in facing the frame sequencer.
// Assumes: One access at a time; ack comes no earlier than one cycle after the request rises.
// Notes:   Load data are the address xor a constant so the bench can predict them.
`timescale 1ns/1ps
`default_nettype none
module fsq_mem_model (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// Access from the sequencer
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	output logic             o_ack,
	output logic             o_fault,
	output logic [31:0]      o_rdata,
	output logic             o_nonidem,
	output logic             o_pending,
	// Bench control
	input  wire logic [3:0]  i_delay,
	input  wire logic        i_fault_en,
	input  wire logic [31:0] i_fault_addr,
	input  wire logic [31:0] i_nonidem_base
);
	logic [3:0] wait_r;
	logic [2:0] pend_r;

	assign o_nonidem = (i_addr >= i_nonidem_base);
	assign o_pending = (pend_r != 3'h0);

	// Repeated accesses to the same words are served like any other
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ack   <= 1'b0;
			o_fault <= 1'b0;
			o_rdata <= 32'h0;
			wait_r  <= 4'h0;
			pend_r  <= 3'h0;
		end else begin
			o_ack   <= 1'b0;
			o_fault <= 1'b0;
			// Released data line keeps toggling so stale values never look valid
			o_rdata <= ~o_rdata;
			if (pend_r != 3'h0)
				pend_r <= pend_r - 3'h1;
			if (i_req && !o_ack) begin
				if (wait_r >= i_delay) begin
					wait_r  <= 4'h0;
					o_ack   <= 1'b1;
					o_fault <= i_fault_en && (i_addr == i_fault_addr);
					o_rdata <= i_addr ^ 32'h5a5a0000;
					// Bus response of a store lags the ack
					if (i_we)
						pend_r <= 3'h4;
				end else
					wait_r <= wait_r + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/stack_frame_push_pop_sequencer_tb.sv ----
// Purpose: Self-checking bench for the stack-frame save/restore sequencer.
// Assumes: 32-bit core, full register set, one access outstanding.
// Notes:   Register file reads return a pattern built from the register number.
`timescale 1ns/1ps
`default_nettype none
module stack_frame_push_pop_sequencer_tb;
	localparam logic [31:0] PC = 32'h00000a40;
	logic                 i_core_clk = 1'b0;
	logic                 i_rst = 1'b1;
	logic                 issue_valid = 1'b0;
	fsq_pkg::fsq_req_t    issue = '0;
	logic                 busy, irq_hold, rf_we, mem_req, mem_we, ack, fault, nonidem, pending;
	logic [4:0]           rf_raddr, rf_waddr;
	logic [31:0]          rf_rdata, rf_wdata, mem_addr, mem_wdata, rdata, reg_rdata;
	logic                 commit_valid, trap_valid;
	fsq_pkg::fsq_commit_t commit, got_c;
	fsq_pkg::fsq_trap_t   trap, got_t;
	logic [7:0]           reg_addr = 8'h0;
	logic [31:0]          reg_wdata = 32'h0;
	logic                 reg_we = 1'b0;
	logic                 reg_re = 1'b0;
	logic [3:0]           delay = 4'h0;
	logic                 fault_en = 1'b0;
	logic [31:0]          fault_addr = 32'h0;
	logic [31:0]          nonidem_base = 32'hffffffff;
	logic [31:0]          aq[$], dq[$], vq[$];
	logic                 wq[$];
	logic [4:0]           rq[$];
	logic                 pend_q = 1'b0;
	bit                   wait_mode = 1'b0;
	int                   n_commit, n_trap, total, i, mismatches, checks_done;
	logic [7:0]           ex [8] = '{8'h1f, 8'h3f, 8'h2a, 8'h61, 8'h50, 8'he0, 8'h66, 8'hb1};
	logic [7:0]           e;

	always #10 i_core_clk = ~i_core_clk;
	assign rf_rdata = {8'hd0, 19'h0, rf_raddr};

	fsq_sequencer u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_issue_valid(issue_valid), .i_issue(issue),
		.o_busy(busy), .o_irq_hold(irq_hold), .o_rf_raddr(rf_raddr), .i_rf_rdata(rf_rdata), .o_rf_we(rf_we),
		.o_rf_waddr(rf_waddr), .o_rf_wdata(rf_wdata), .o_mem_req(mem_req), .o_mem_we(mem_we),
		.o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_mem_ack(ack), .i_mem_fault(fault),
		.i_mem_rdata(rdata), .i_attr_nonidem(nonidem), .i_store_pending(pending),
		.o_commit_valid(commit_valid), .o_commit(commit), .o_trap_valid(trap_valid), .o_trap(trap),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_we(reg_we), .i_reg_re(reg_re),
		.o_reg_rdata(reg_rdata));

	fsq_mem_model u_mem (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(mem_req), .i_we(mem_we),
		.i_addr(mem_addr), .o_ack(ack), .o_fault(fault), .o_rdata(rdata), .o_nonidem(nonidem),
		.o_pending(pending), .i_delay(delay), .i_fault_en(fault_en), .i_fault_addr(fault_addr),
		.i_nonidem_base(nonidem_base));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Values are sampled before this edge's updates land
	always @(posedge i_core_clk) begin
		if (!i_rst) begin
			if (mem_req && ack) begin
				aq.push_back(mem_addr);
				wq.push_back(mem_we);
				dq.push_back(mem_wdata);
			end
			if (rf_we) begin
				rq.push_back(rf_waddr);
				vq.push_back(rf_wdata);
			end
			if (commit_valid) begin
				n_commit++;
				got_c = commit;
			end
			if (trap_valid) begin
				n_trap++;
				got_t = trap;
			end
			if (commit_valid && wait_mode)
				cmp(pend_q, 1'b0);
			pend_q = pending;
			cmp(irq_hold, busy);
			if (mem_req || rf_we)
				cmp({busy, irq_hold}, 2'b11);
			if (commit_valid || trap_valid)
				cmp(busy, 1'b0);
		end
	end

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		reg_we    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge i_core_clk);
		reg_we <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_core_clk);
		reg_re   <= 1'b1;
		reg_addr <= a;
		@(posedge i_core_clk);
		reg_re <= 1'b0;
		#1;
		cmp(reg_rdata, exp);
	endtask

	// Issues one instruction; a poke re-issues while busy, which must be ignored
	task automatic run(input logic [1:0] op, input logic [3:0] rl, input logic [1:0] si, input logic [31:0] sp,
		input bit poke);
		int n;
		aq.delete();
		wq.delete();
		dq.delete();
		rq.delete();
		vq.delete();
		n_commit = 0;
		n_trap = 0;
		@(posedge i_core_clk);
		issue_valid <= 1'b1;
		issue       <= {op, rl, si, PC, sp};
		@(posedge i_core_clk);
		issue_valid <= poke;
		issue.stack_pointer <= sp + 32'h100;
		@(posedge i_core_clk);
		issue_valid <= 1'b0;
		for (n = 0; n < 600 && n_commit + n_trap == 0; n++) begin
			@(posedge i_core_clk);
			#1;
		end
		cmp(n_commit + n_trap, 1);
		total += n_commit;
		@(posedge i_core_clk);
	endtask

	task automatic expect_ok(input logic [1:0] op, input logic [3:0] rl, input logic [1:0] si, input logic [31:0] sp);
		logic [31:0] adj, a;
		logic [4:0]  r;
		int          m, k;
		m = (rl == 4'hf) ? 12 : rl - 4;
		adj = (rl < 8 ? 16 : rl < 12 ? 32 : rl < 15 ? 48 : 64) + si * 16;
		cmp(aq.size(), m + 1);
		for (k = 0; k <= m && k < aq.size(); k++) begin
			r = (k == m) ? 5'h01 : (m - 1 - k < 2) ? 5'(8 + m - 1 - k) : 5'(16 + m - 1 - k);
			a = (op == 2'd0) ? sp - 4 * (k + 1) : sp + adj - 4 * (k + 1);
			cmp(aq[k], a);
			cmp(wq[k], op == 2'd0);
			if (op == 2'd0)
				cmp(dq[k], {8'hd0, 19'h0, r});
			else if (k < rq.size()) begin
				cmp(rq[k], r);
				cmp(vq[k], a ^ 32'h5a5a0000);
			end
		end
		if (op != 2'd0)
			cmp(rq.size(), m + 1);
		cmp(n_commit, 1);
		cmp(got_c.stack_pointer, op == 2'd0 ? sp - adj : sp + adj);
		cmp({got_c.zero_first_arg, got_c.ret}, {op == 2'd3, op >= 2'd2});
	endtask

	task automatic expect_trap(input logic [31:0] val, input logic [4:0] why, input int nacc);
		cmp(n_trap, 1);
		cmp(n_commit, 0);
		cmp(got_t.pc, PC);
		cmp(got_t.value, val);
		cmp(got_t.reason, why);
		cmp(aq.size(), nacc);
	endtask

	initial begin
		repeat (60000) @(posedge i_core_clk);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge i_core_clk);
		i_rst <= 1'b0;
		reg_rd(fsq_pkg::REG_CTRL, 32'h0);
		reg_rd(fsq_pkg::REG_STATUS, 32'h0);
		reg_rd(fsq_pkg::REG_COMMITS, 32'h0);
		reg_rd(8'h0c, 32'h0);
		reg_wr(fsq_pkg::REG_STATUS, 32'hffff);
		reg_rd(fsq_pkg::REG_STATUS, 32'h0);
		// Documented examples first, then each list code from 4 to 15 with one operation
		for (i = 0; i < 20; i++) begin
			e = (i < 8) ? ex[i] : {2'(i % 4), 4'(i - 4), 2'((i / 3) % 4)};
			delay <= 4'(i % 3);
			run(e[7:6], e[5:2], e[1:0], 32'h1000 + i * 256, i == 1);
			expect_ok(e[7:6], e[5:2], e[1:0], 32'h1000 + i * 256);
		end
		for (i = 0; i < 4; i++) begin
			run(2'(i), 4'(i), 2'd1, 32'h1800, 1'b0);
			expect_trap(32'h0, fsq_pkg::CAUSE_ILLEGAL, 0);
		end
		// Two traps on one instruction, then a clean restart
		fault_addr <= 32'h1ff4;
		fault_en   <= 1'b1;
		run(2'd0, 4'd8, 2'd0, 32'h2000, 1'b0);
		expect_trap(32'h1ff4, fsq_pkg::CAUSE_STORE_ACC, 3);
		run(2'd0, 4'd8, 2'd0, 32'h2000, 1'b0);
		expect_trap(32'h1ff4, fsq_pkg::CAUSE_STORE_ACC, 3);
		reg_rd(fsq_pkg::REG_STATUS, 32'h600);
		fault_en <= 1'b0;
		run(2'd0, 4'd8, 2'd0, 32'h2000, 1'b0);
		expect_ok(2'd0, 4'd8, 2'd0, 32'h2000);
		reg_rd(fsq_pkg::REG_STATUS, 32'h0);
		reg_wr(fsq_pkg::REG_CTRL, 32'h4);
		fault_addr <= 32'h300c;
		fault_en   <= 1'b1;
		run(2'd1, 4'd5, 2'd0, 32'h3000, 1'b0);
		expect_trap(32'h0, fsq_pkg::CAUSE_LOAD_ACC, 1);
		fault_en <= 1'b0;
		reg_wr(fsq_pkg::REG_CTRL, 32'h1);
		nonidem_base <= 32'h0;
		run(2'd0, 4'd4, 2'd0, 32'h4000, 1'b0);
		expect_trap(32'h3ffc, fsq_pkg::CAUSE_STORE_ACC, 0);
		run(2'd1, 4'd4, 2'd0, 32'h4000, 1'b0);
		expect_trap(32'h400c, fsq_pkg::CAUSE_LOAD_ACC, 0);
		nonidem_base <= 32'hffffffff;
		reg_wr(fsq_pkg::REG_CTRL, 32'h2);
		wait_mode = 1'b1;
		run(2'd0, 4'd6, 2'd0, 32'h5000, 1'b0);
		expect_ok(2'd0, 4'd6, 2'd0, 32'h5000);
		wait_mode = 1'b0;
		reg_rd(fsq_pkg::REG_CTRL, 32'h2);
		reg_rd(fsq_pkg::REG_COMMITS, 32'(total));
		summarize();
	end
endmodule
`default_nettype wire
